//--- core/rms_consts.vh
// Constants for the runtime miscellaneous register slice.
// Included by the slice only, not by its edge detector; definitions only.
`ifndef RMS_CONSTS_VH
`define RMS_CONSTS_VH

// Register byte offsets (consecutive, one byte address each).
`define RMS_OFS_IRQ_EN4 8'h1B
`define RMS_OFS_EDGE_STS 8'h1C
`define RMS_OFS_RST_SEL 8'h1D
`define RMS_OFS_FORCE_CHG 8'h1E
`define RMS_OFS_FLOPPY_RATE 8'h1F
`define RMS_OFS_SER1_FIFO 8'h20
`define RMS_OFS_SER2_FIFO 8'h21
`define RMS_OFS_SER3_FIFO 8'h22
`define RMS_OFS_PIN10_CFG 8'h23
`define RMS_OFS_SRC_FLAGS 8'h24
`define RMS_OFS_MGMT_CTL 8'h25

// Reset values.
`define RMS_RST_IRQ_EN4 8'h00
`define RMS_RST_EDGE_STS 8'h00
`define RMS_RST_RST_SEL 8'h00
`define RMS_RST_FORCE_CHG 8'h03
`define RMS_RST_PIN10_CFG 8'h01
`define RMS_RST_MGMT_CTL 8'h00

// Field positions and masks.
`define RMS_STS_W1C_MASK 8'h3F
`define RMS_STS_LIVE_MASK 8'h33
`define RMS_EN4_SER_MASK 8'h53
`define RMS_RSEL_WDT_DIS 0
`define RMS_RSEL_THERM 1
`define RMS_RSEL_WDT_IN 2
`define RMS_RSEL_MASK 8'h07
`define RMS_FCHG_MASK 8'h03
`define RMS_PCFG_DIR 0
`define RMS_PCFG_INV 1
`define RMS_PCFG_ALT 2
`define RMS_PCFG_OD 7
`define RMS_PCFG_MASK_2P 8'h83
`define RMS_PCFG_MASK_4P 8'h87
`define RMS_FIFO_MASK 8'hCF
`define RMS_RATE_MASK 8'hDF
`define RMS_MCTL_PIN 0
`define RMS_MCTL_SIRQ 1
`define RMS_MCTL_WAKE 2
`define RMS_MCTL_MASK 8'h07

// Number of serial ports in the variant: 2, 4 or 6.
`define RMS_PORTS_DEFAULT 6

`endif

//--- core/rms_edge_sync.v
// Three-stage synchroniser with either-edge pulse for one pin.
// Assumes clk_i free-running and rst_i synchronous active high.
`timescale 1ns/1ps
module rms_edge_sync (
    // Clock and reset
    input wire clk_i,
    input wire rst_i,
    // Pin and result
    input wire pin_i,
    output wire level_o,
    output wire edge_o
);
    reg [2:0] sync;
    reg last;
    reg primed;
    reg [1:0] fill;

    // Stage 0 feeds stage 1 only; a change counts once stages 1 and 2 agree.
    always @(posedge clk_i) begin
        if (rst_i) begin
            sync <= 3'h0;
            last <= 1'b0;
            primed <= 1'b0;
            fill <= 2'h0;
        end else begin
            sync <= {sync[1:0], pin_i};
            if (fill != 2'h3) begin
                fill <= fill + 2'h1;
            end
            // No edge is reported before the stages hold the real pin, so reset leaves no false edge.
            if (sync[2] == sync[1]) begin
                last <= sync[2];
                primed <= (fill == 2'h3);
            end
        end
    end

    assign level_o = last;
    assign edge_o = primed && (sync[2] == sync[1]) && (sync[2] != last);
endmodule // rms_edge_sync

//--- core/rms_slice.v
// Runtime miscellaneous register slice: offsets 0x1B to 0x23 plus two extras.
// Assumes a classic Wishbone master on clk_i; pins arrive asynchronously.
`timescale 1ns/1ps
`include "rms_consts.vh"
module rms_slice #(
    parameter PORTS = `RMS_PORTS_DEFAULT
) (
    // Clock and reset
    input wire clk_i,
    input wire rst_i,
    // Wishbone slave
    input wire cyc_i,
    input wire stb_i,
    input wire we_i,
    input wire [7:0] adr_i,
    input wire [3:0] sel_i,
    input wire [31:0] dat_i,
    output reg [31:0] dat_o,
    output reg ack_o,
    output reg err_o,
    // Edge-triggered pins
    input wire edge_pin_a_i,
    input wire edge_pin_b_i,
    input wire edge_pin_c_i,
    input wire edge_pin_d_i,
    // Gated pin sources and serial interrupts
    input wire gated_pin_e_i,
    input wire gated_pin_f_i,
    input wire gated_pin_g_i,
    input wire pin_61_src_i,
    input wire serial3_irq_i,
    input wire serial4_irq_i,
    input wire serial5_irq_i,
    input wire serial6_irq_i,
    // Management interrupt outputs
    output wire mgmt_irq_o,
    output wire mgmt_irq_pin_n_o,
    output wire mgmt_irq_sirq_o,
    output wire mgmt_irq_wake_o,
    // Power-good sources
    input wire watchdog_expired_i,
    input wire thermal_trip_i,
    output wire watchdog_input_bit_o,
    output wire power_good_output_o,
    // Floppy interface
    input wire step_strobe_n_i,
    input wire drive_select_0_n_i,
    input wire drive_select_1_n_i,
    input wire media_change_input_n_i,
    output wire media_change_indication_o,
    // Mirrored settings
    input wire [7:0] floppy_rate_i,
    input wire [7:0] serial1_fifo_ctl_i,
    input wire [7:0] serial2_fifo_ctl_i,
    input wire [7:0] serial3_fifo_ctl_i,
    // Pin 1.0
    input wire pin_1_0_i,
    output wire pin_1_0_o,
    output wire pin_1_0_oe_o,
    output wire pin_1_0_level_o,
    output wire serial3_receive_line_o
);
    localparam [7:0] PCFG_MASK = (PORTS > 2) ? `RMS_PCFG_MASK_4P : `RMS_PCFG_MASK_2P;

    reg [7:0] group_irq_enable_4;
    reg [7:0] misc_edge_status;
    reg [7:0] reset_source_select;
    reg [7:0] force_media_change;
    reg [7:0] pin_1_0_config;
    reg [7:0] mgmt_ctl;
    reg [7:0] next_status;
    reg [7:0] next_force;
    reg [7:0] rd_byte;
    reg hit;

    wire [3:0] pin_edge;
    wire [3:0] pin_level;
    wire [3:0] pin_raw;
    wire [2:0] fl_level;
    wire [2:0] fl_raw;
    wire [2:0] fl_edge;
    wire pin10_level;
    wire step_fall;
    wire [7:0] edge_set;
    wire [7:0] rd_status;
    wire [7:0] rd_rate;
    wire [7:0] rd_ser1;
    wire [7:0] rd_ser2;
    wire [7:0] rd_ser3;
    wire wr_en4;
    wire wr_sts;
    wire wr_rsel;
    wire wr_fchg;
    wire wr_pcfg;
    wire wr_mctl;
    wire wdt_src;
    wire therm_src;
    wire pin_dir_in;
    wire pin_inv;
    wire pin_od;
    wire [7:0] irq_src;
    wire req;
    wire wr;
    wire wr_lane;

    assign pin_raw = {edge_pin_d_i, edge_pin_c_i, edge_pin_b_i, edge_pin_a_i};
    assign fl_raw = {drive_select_1_n_i, drive_select_0_n_i, step_strobe_n_i};

    // Edge detection for the four status pins and the three floppy pins; pin 1.0 is synchronised for its level only.
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_edge
            rms_edge_sync u_sync (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .pin_i(pin_raw[gi]),
                .level_o(pin_level[gi]),
                .edge_o(pin_edge[gi])
            );
        end
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_fl
            rms_edge_sync u_sync (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .pin_i(fl_raw[gi]),
                .level_o(fl_level[gi]),
                .edge_o(fl_edge[gi])
            );
        end
    endgenerate

    rms_edge_sync u_pin10 (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i(pin_1_0_i),
        .level_o(pin10_level),
        .edge_o()
    );

    // Bus decode: one cycle answer, lane 0 carries the byte.
    assign req = cyc_i && stb_i && !ack_o && !err_o;
    assign wr = req && we_i && hit;
    assign wr_lane = wr && sel_i[0];

    // Write strobes, one per writable register.
    assign wr_en4 = wr_lane && (adr_i == `RMS_OFS_IRQ_EN4);
    assign wr_sts = wr_lane && (adr_i == `RMS_OFS_EDGE_STS);
    assign wr_rsel = wr_lane && (adr_i == `RMS_OFS_RST_SEL);
    assign wr_fchg = wr_lane && (adr_i == `RMS_OFS_FORCE_CHG);
    assign wr_pcfg = wr_lane && (adr_i == `RMS_OFS_PIN10_CFG);
    assign wr_mctl = wr_lane && (adr_i == `RMS_OFS_MGMT_CTL);

    // Read views, reserved positions forced to zero.
    assign rd_status = misc_edge_status & `RMS_STS_LIVE_MASK;
    assign rd_rate = floppy_rate_i & `RMS_RATE_MASK;
    assign rd_ser1 = serial1_fifo_ctl_i & `RMS_FIFO_MASK;
    assign rd_ser2 = serial2_fifo_ctl_i & `RMS_FIFO_MASK;
    assign rd_ser3 = (PORTS > 2) ? (serial3_fifo_ctl_i & `RMS_FIFO_MASK) : 8'h00;

    always @* begin
        hit = 1'b1;
        case (adr_i)
            `RMS_OFS_IRQ_EN4: rd_byte = group_irq_enable_4;
            `RMS_OFS_EDGE_STS: rd_byte = rd_status;
            `RMS_OFS_RST_SEL: rd_byte = reset_source_select;
            `RMS_OFS_FORCE_CHG: rd_byte = force_media_change;
            `RMS_OFS_FLOPPY_RATE: rd_byte = rd_rate;
            `RMS_OFS_SER1_FIFO: rd_byte = rd_ser1;
            `RMS_OFS_SER2_FIFO: rd_byte = rd_ser2;
            `RMS_OFS_SER3_FIFO: rd_byte = rd_ser3;
            `RMS_OFS_PIN10_CFG: rd_byte = pin_1_0_config;
            `RMS_OFS_SRC_FLAGS: rd_byte = {4'h0, pin_level};
            `RMS_OFS_MGMT_CTL: rd_byte = mgmt_ctl;
            default: begin
                rd_byte = 8'h00;
                hit = 1'b0;
            end
        endcase
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
        end else begin
            ack_o <= req && hit;
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            err_o <= 1'b0;
        end else begin
            err_o <= req && !hit;
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= 32'h0;
        end else begin
            dat_o <= (req && hit && !we_i) ? {24'h0, rd_byte} : 32'h0;
        end
    end

    assign edge_set = {2'b00, pin_edge[3:2], 2'b00, pin_edge[1:0]};

    // Status flags: hardware set wins over a same-cycle software clear.
    always @* begin
        next_status = misc_edge_status;
        if (wr_sts) begin
            next_status = next_status & ~(dat_i[7:0] & `RMS_STS_W1C_MASK);
        end
        next_status = next_status | edge_set;
        next_status = next_status & `RMS_STS_LIVE_MASK;
    end

    // Force-change bits: step falling edge with active-low select clears.
    assign step_fall = fl_edge[0] && fl_level[0];

    always @* begin
        next_force = force_media_change;
        if (wr_fchg) begin
            next_force = next_force | (dat_i[7:0] & `RMS_FCHG_MASK);
        end
        if (step_fall && !fl_level[1]) begin
            next_force[0] = 1'b0;
        end
        if (step_fall && !fl_level[2]) begin
            next_force[1] = 1'b0;
        end
    end

    // Register storage, one process per register.
    always @(posedge clk_i) begin
        if (rst_i) begin
            group_irq_enable_4 <= `RMS_RST_IRQ_EN4;
        end else if (wr_en4) begin
            group_irq_enable_4 <= dat_i[7:0];
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            misc_edge_status <= `RMS_RST_EDGE_STS;
        end else begin
            misc_edge_status <= next_status;
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            reset_source_select <= `RMS_RST_RST_SEL;
        end else if (wr_rsel) begin
            reset_source_select <= dat_i[7:0] & `RMS_RSEL_MASK;
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            force_media_change <= `RMS_RST_FORCE_CHG;
        end else begin
            force_media_change <= next_force;
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            pin_1_0_config <= `RMS_RST_PIN10_CFG;
        end else if (wr_pcfg) begin
            pin_1_0_config <= dat_i[7:0] & PCFG_MASK;
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            mgmt_ctl <= `RMS_RST_MGMT_CTL;
        end else if (wr_mctl) begin
            mgmt_ctl <= dat_i[7:0] & `RMS_MCTL_MASK;
        end
    end

    // Management interrupt: serial gates exist only with enough ports.
    assign irq_src = {pin_61_src_i,
                      (PORTS > 4) ? serial6_irq_i : 1'b0,
                      gated_pin_g_i,
                      (PORTS > 4) ? serial5_irq_i : 1'b0,
                      gated_pin_f_i,
                      gated_pin_e_i,
                      (PORTS > 2) ? serial4_irq_i : 1'b0,
                      (PORTS > 2) ? serial3_irq_i : 1'b0};
    assign mgmt_irq_o = |(irq_src & group_irq_enable_4);
    assign mgmt_irq_pin_n_o = !(mgmt_irq_o && mgmt_ctl[`RMS_MCTL_PIN]);
    assign mgmt_irq_sirq_o = mgmt_irq_o && mgmt_ctl[`RMS_MCTL_SIRQ];
    assign mgmt_irq_wake_o = mgmt_irq_o && mgmt_ctl[`RMS_MCTL_WAKE];

    // Power-good generation.
    assign watchdog_input_bit_o = reset_source_select[`RMS_RSEL_WDT_IN];
    assign wdt_src = watchdog_expired_i && !reset_source_select[`RMS_RSEL_WDT_DIS];
    assign therm_src = thermal_trip_i && reset_source_select[`RMS_RSEL_THERM];
    assign power_good_output_o = !(wdt_src || therm_src);

    // Media-change indication, active-high, from active-low inputs.
    assign media_change_indication_o = (!drive_select_0_n_i && force_media_change[0]) ||
                                       (!drive_select_1_n_i && force_media_change[1]) ||
                                       !media_change_input_n_i;

    // Pin 1.0: direction, polarity, open-drain and alternate route.
    wire pin_alt;
    wire pin_out_val;
    assign pin_dir_in = pin_1_0_config[`RMS_PCFG_DIR];
    assign pin_inv = pin_1_0_config[`RMS_PCFG_INV];
    assign pin_od = pin_1_0_config[`RMS_PCFG_OD];
    assign pin_alt = (PORTS > 2) && pin_1_0_config[`RMS_PCFG_ALT];
    assign pin_out_val = pin_inv;
    assign pin_1_0_level_o = pin10_level ^ pin_inv;
    assign serial3_receive_line_o = pin_alt ? pin10_level : 1'b1;
    assign pin_1_0_o = pin_od ? 1'b0 : pin_out_val;
    assign pin_1_0_oe_o = !pin_alt && !pin_dir_in && (!pin_od || !pin_out_val);
endmodule // rms_slice

//--- tb/rms_slice_sva.sv
// Checker with port-level properties of the register slice.
// Assumes it is bound to rms_slice; one clock, synchronous active-high reset.
`timescale 1ns/1ps
module rms_slice_sva (
    // Clock, reset and bus
    input wire clk_i,
    input wire rst_i,
    input wire cyc_i,
    input wire stb_i,
    input wire we_i,
    input wire [7:0] adr_i,
    input wire [3:0] sel_i,
    input wire [31:0] dat_i,
    input wire [31:0] dat_o,
    input wire ack_o,
    input wire err_o,
    // Watched pins
    input wire watchdog_expired_i,
    input wire thermal_trip_i,
    input wire power_good_output_o,
    input wire drive_select_0_n_i,
    input wire drive_select_1_n_i,
    input wire media_change_input_n_i,
    input wire media_change_indication_o,
    input wire [7:0] floppy_rate_i
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire req = cyc_i && stb_i && !ack_o && !err_o;
    wire mapped = adr_i >= 8'h1B && adr_i <= 8'h25;
    property p_ack; req && mapped |=> ack_o && !err_o ##1 !ack_o; endproperty
    a_ack: assert property (p_ack) else $error("mapped request not acked once");
    property p_err; req && !mapped |=> err_o && !ack_o; endproperty
    a_err: assert property (p_err) else $error("unmapped request not refused");
    property p_rate; ack_o && $past(!we_i && adr_i == 8'h1F) |-> dat_o == {24'h0, $past(floppy_rate_i) & 8'hDF}; endproperty
    a_rate: assert property (p_rate) else $error("rate mirror read wrong");
    property p_sts; ack_o && $past(!we_i && adr_i == 8'h1C) |-> (dat_o & 32'hFFFFFFCC) == 32'h0; endproperty
    a_sts: assert property (p_sts) else $error("status reserved bits not zero");
    property p_pg; !watchdog_expired_i && !thermal_trip_i |-> power_good_output_o; endproperty
    a_pg: assert property (p_pg) else $error("power good low without source");
    // Watchdog-disable bit as software last wrote it.
    reg wdt_dis = 1'b0;
    always @(posedge clk_i) begin
        if (rst_i) wdt_dis <= 1'b0;
        else if (req && we_i && sel_i[0] && adr_i == 8'h1D) wdt_dis <= dat_i[0];
    end
    property p_wdt; watchdog_expired_i && !wdt_dis |-> !power_good_output_o; endproperty
    a_wdt: assert property (p_wdt) else $error("watchdog not a source after reset");
    property p_mc_pin; !media_change_input_n_i |-> media_change_indication_o; endproperty
    a_mc_pin: assert property (p_mc_pin) else $error("media change pin not passed");
    property p_mc_idle; drive_select_0_n_i && drive_select_1_n_i && media_change_input_n_i |-> !media_change_indication_o; endproperty
    a_mc_idle: assert property (p_mc_idle) else $error("media change without select");
endmodule // rms_slice_sva

//--- tb/rms_slice_test.sv
// Self-checking testbench for the register slice.
// Assumes a classic Wishbone master role and a 100 ns clock.
`timescale 1ns/1ps
module rms_slice_test;
    reg clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
    reg [7:0] adr_i = 8'h00;
    reg [31:0] dat_i = 32'h0;
    reg [7:0] src = 8'h00, fl = 8'h00, s1 = 8'h00, s2 = 8'h00, s3 = 8'h00, q;
    reg [3:0] ep = 4'h0;
    reg [3:0] sel = 4'hF, lanes = 4'hF;
    reg wdt = 0, thr = 0, step_n = 1, ds0_n = 1, ds1_n = 1, mc_n = 1, pin_i = 1, e;
    wire [31:0] dat_o;
    wire ack_o, err_o, irq, irq_n, wib, pg, mci, oe, rxl, sirq, wake, pout, plvl;
    integer num_errors = 0, checks_done = 0, i;
    initial forever #50 clk_i = ~clk_i;
    rms_slice #(.PORTS(6)) dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o),
        .edge_pin_a_i(ep[0]), .edge_pin_b_i(ep[1]), .edge_pin_c_i(ep[2]), .edge_pin_d_i(ep[3]),
        .serial3_irq_i(src[0]), .serial4_irq_i(src[1]), .gated_pin_e_i(src[2]), .gated_pin_f_i(src[3]),
        .serial5_irq_i(src[4]), .gated_pin_g_i(src[5]), .serial6_irq_i(src[6]), .pin_61_src_i(src[7]),
        .mgmt_irq_o(irq), .mgmt_irq_pin_n_o(irq_n), .mgmt_irq_sirq_o(sirq), .mgmt_irq_wake_o(wake),
        .watchdog_expired_i(wdt), .thermal_trip_i(thr), .watchdog_input_bit_o(wib), .power_good_output_o(pg),
        .step_strobe_n_i(step_n), .drive_select_0_n_i(ds0_n), .drive_select_1_n_i(ds1_n),
        .media_change_input_n_i(mc_n), .media_change_indication_o(mci), .floppy_rate_i(fl),
        .serial1_fifo_ctl_i(s1), .serial2_fifo_ctl_i(s2), .serial3_fifo_ctl_i(s3), .pin_1_0_i(pin_i),
        .pin_1_0_o(pout), .pin_1_0_oe_o(oe), .pin_1_0_level_o(plvl), .serial3_receive_line_o(rxl));
    task chk(input string nm, input [31:0] seen, input [31:0] exp);
        begin
            checks_done = checks_done + 1;
            if (seen !== exp) begin
                num_errors = num_errors + 1;
                $display("[ERR] %0s expected %h seen %h", nm, exp, seen);
            end
        end
    endtask
    // One classic cycle; entered just after a rising edge, leaves one idle cycle.
    task bus(input [7:0] a, input w, input [7:0] d);
        begin
            cyc_i <= 1;
            stb_i <= 1;
            we_i <= w;
            sel <= lanes;
            adr_i <= a;
            dat_i <= {24'h0, d};
            @(posedge clk_i);
            while (!(ack_o || err_o)) @(posedge clk_i);
            q = dat_o[7:0];
            e = err_o;
            cyc_i <= 0;
            stb_i <= 0;
            @(posedge clk_i);
        end
    endtask
    task wr(input [7:0] a, input [7:0] d);
        bus(a, 1'b1, d);
    endtask
    task rd(input [7:0] a, input [7:0] x);
        begin
            bus(a, 1'b0, 8'h00);
            chk("register", {a, q}, {a, x});
        end
    endtask
    task summarize;
        begin
            $display("checks %0d errors %0d", checks_done, num_errors);
            if (num_errors == 0 && checks_done > 0) $display("TEST PASSED");
            else $display("TEST FAILED");
            $finish;
        end
    endtask
    initial begin
        #200000;
        num_errors = num_errors + 1;
        summarize;
    end
    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 0;
        repeat (4) @(posedge clk_i);
        rd(8'h1B, 8'h00);
        rd(8'h1C, 8'h00);
        rd(8'h1D, 8'h00);
        rd(8'h1E, 8'h03);
        rd(8'h23, 8'h01);
        chk("oe", oe, 0);
        for (i = 0; i < 8; i = i + 1) begin
            src <= 8'h01 << i;
            wr(8'h1B, 8'h01 << i);
            chk("irq on", irq, 1);
            wr(8'h1B, ~(8'h01 << i));
            chk("irq off", irq, 0);
        end
        wr(8'h1B, 8'h80);
        wr(8'h25, 8'h01);
        chk("irq pin", irq_n, 0);
        wr(8'h25, 8'h07);
        chk("irq sirq", sirq, 1);
        chk("irq wake", wake, 1);
        rd(8'h25, 8'h07);
        wr(8'h1B, 8'h00);
        chk("irq pin", irq_n, 1);
        chk("irq sirq", sirq, 0);
        src <= 8'h00;
        lanes = 4'hE;
        wr(8'h1B, 8'hFF);
        lanes = 4'hF;
        rd(8'h1B, 8'h00);
        ep <= 4'hF;
        repeat (8) @(posedge clk_i);
        rd(8'h1C, 8'h33);
        rd(8'h24, 8'h0F);
        wr(8'h1C, 8'h01);
        rd(8'h1C, 8'h32);
        wr(8'h1C, 8'hC0);
        rd(8'h1C, 8'h32);
        wr(8'h1C, 8'hFF);
        rd(8'h1C, 8'h00);
        ep <= 4'h0;
        repeat (8) @(posedge clk_i);
        rd(8'h1C, 8'h33);
        wdt <= 1;
        @(posedge clk_i);
        chk("pg", pg, 0);
        wr(8'h1D, 8'h07);
        chk("pg", pg, 1);
        chk("wdt bit", wib, 1);
        thr <= 1;
        @(posedge clk_i);
        chk("pg", pg, 0);
        wr(8'h1D, 8'hFD);
        rd(8'h1D, 8'h05);
        chk("pg", pg, 1);
        ds0_n <= 0;
        @(posedge clk_i);
        chk("mc", mci, 1);
        step_n <= 0;
        repeat (8) @(posedge clk_i);
        rd(8'h1E, 8'h02);
        chk("mc", mci, 0);
        wr(8'h1E, 8'h00);
        rd(8'h1E, 8'h02);
        step_n <= 1;
        ds0_n <= 1;
        wr(8'h1E, 8'h01);
        rd(8'h1E, 8'h03);
        mc_n <= 0;
        @(posedge clk_i);
        chk("mc", mci, 1);
        mc_n <= 1;
        fl <= 8'hFF;
        s1 <= 8'hFF;
        s2 <= 8'hFF;
        s3 <= 8'hFF;
        @(posedge clk_i);
        rd(8'h1F, 8'hDF);
        for (i = 8'h20; i < 8'h23; i = i + 1) rd(i[7:0], 8'hCF);
        wr(8'h23, 8'hFF);
        rd(8'h23, 8'h87);
        wr(8'h23, 8'h00);
        chk("oe", oe, 1);
        chk("pin out", pout, 0);
        chk("pin level", plvl, 1);
        wr(8'h23, 8'h02);
        chk("pin out", pout, 1);
        chk("pin level", plvl, 0);
        wr(8'h23, 8'h82);
        chk("oe", oe, 0);
        wr(8'h23, 8'h05);
        pin_i <= 0;
        repeat (6) @(posedge clk_i);
        chk("rx", rxl, 0);
        chk("pin level", plvl, 0);
        bus(8'h30, 1'b0, 8'h00);
        chk("err", e, 1);
        summarize;
    end
endmodule // rms_slice_test
bind rms_slice rms_slice_sva chk_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o),
    .watchdog_expired_i(watchdog_expired_i),
    .thermal_trip_i(thermal_trip_i), .power_good_output_o(power_good_output_o),
    .drive_select_0_n_i(drive_select_0_n_i), .drive_select_1_n_i(drive_select_1_n_i),
    .media_change_input_n_i(media_change_input_n_i), .media_change_indication_o(media_change_indication_o),
    .floppy_rate_i(floppy_rate_i));
